// ==== frame_align_pkg.sv ====
/*
  Shared constants and carriers for the serial input frame aligner:
  register offsets, field positions, reset values and the word format
  pushed into the receive FIFO.
  Assumes a 32-bit APB register bus and one system clock.
*/
package frame_align_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RXDATA_OFS = 8'h08;
  localparam logic [7:0] FRAMES_OFS = 8'h0C;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_NATIVE_BIT = 1;
  localparam int CTRL_LATCH_BIT  = 2;
  localparam int CTRL_OFS_LSB    = 4;
  localparam int CTRL_OFS_MSB    = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // ----------------------------------------------------------------
  // Status fields, sticky bits are write-one-to-clear
  // ----------------------------------------------------------------
  localparam int STAT_NOT_EMPTY_BIT = 0;
  localparam int STAT_OVERRUN_BIT   = 1;
  localparam int STAT_RESYNC_BIT    = 2;
  localparam int STAT_LOCKED_BIT    = 3;

  // Receive data word: valid, frame start, channel, data
  localparam int RXD_VALID_BIT = 31;
  localparam int RXD_SOF_BIT   = 16;
  localparam int RXD_CHAN_LSB  = 8;

  // Largest usable offset in clock periods
  localparam logic [2:0] OFFSET_MAX = 3'h4;

  localparam int BYTE_BITS = 8;

  typedef struct packed {
    logic       enable;
    logic       native_serial_mode;
    logic       latch_edge_select;
    logic [2:0] stream_offset_bits;
  } ctrl_s;

  typedef struct packed {
    logic       sof;
    logic [7:0] chan;
    logic [7:0] data;
  } rx_word_s;

endpackage

// ==== rx_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous reset copy from the top.
*/
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("rx_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;

  wire full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  wire push  = in_valid && !full;
  wire pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  // Storage needs no reset; reads are qualified by out_valid
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
  end

endmodule

// ==== serial_edge_sampler.sv ====
/*
  Finds the chosen edge of the serial clock, which is sampled as an
  ordinary input, and takes the data and frame pulse on that edge.
  Assumes all pins are synchronous to clk_sys and the serial clock is
  at most a quarter of clk_sys so no edge is missed.
*/
`timescale 1ns/1ps
module serial_edge_sampler (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Pins
  input  wire logic serial_clock,
  input  wire logic serial_stream_input,
  input  wire logic frame_pulse_input,
  // Edge choice
  input  wire logic sample_on_rise,
  // Sampled results
  output logic      edge_pulse,
  output logic      data_bit,
  output logic      frame_bit
);

  logic clk_prev_ff;
  logic primed_ff;
  logic edge_ff;
  logic data_ff;
  logic frame_ff;

  wire rise_seen = serial_clock && !clk_prev_ff;
  wire fall_seen = !serial_clock && clk_prev_ff;
  // No edge before the pin level is known, else an idle-high clock fakes one
  wire hit       = primed_ff && (sample_on_rise ? rise_seen : fall_seen);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_prev_ff <= 1'b0;
      primed_ff   <= 1'b0;
      edge_ff     <= 1'b0;
      data_ff     <= 1'b0;
      frame_ff    <= 1'b0;
    end
    else
    begin
      clk_prev_ff <= serial_clock;
      primed_ff   <= 1'b1;
      edge_ff     <= hit;
      if (hit)
      begin
        data_ff  <= serial_stream_input;
        frame_ff <= frame_pulse_input;
      end
    end
  end

  assign edge_pulse = edge_ff;
  assign data_bit   = data_ff;
  assign frame_bit  = frame_ff;

endmodule

// ==== input_frame_offset_latch.sv ====
/*
  Receive aligner for one serial input stream: finds the frame pulse,
  waits the programmed offset, then takes bits on the chosen serial
  clock edge, packs them into channel bytes and queues them for
  software over APB.
  Assumes an APB master on clk_sys and a serial clock, stream and
  frame pulse that are synchronous to clk_sys.

  // Operation
  // - Offset field decides when bit 0 of a new frame is taken.
  // - Offset reaches up to four clock periods after the frame pulse.
  // - Native mode, latch edge clear: take bits on the rising edge.
  // - Native mode, latch edge set: take bits on the falling edge.
  // - GCI mode, latch edge clear: take bits on the falling edge.
  // - GCI mode, latch edge set: take bits on the rising edge.
*/
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module input_frame_offset_latch
  import frame_align_pkg::*;
#(
  parameter int FRAME_BITS    = 256,
  parameter int CLKS_PER_BIT  = 2,
  parameter int FIFO_DEPTH    = 8
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  input  wire logic        serial_clock,
  input  wire logic        serial_stream_input,
  input  wire logic        frame_pulse_input,
  // Status
  output logic             frame_locked
);

  import frame_align_pkg::*;

  localparam int BW = $clog2(FRAME_BITS + 1);
  localparam int PW = (CLKS_PER_BIT > 1) ? $clog2(CLKS_PER_BIT) : 1;
  localparam int WW = $bits(rx_word_s);

  initial
  begin
    if (FRAME_BITS < BYTE_BITS || (FRAME_BITS % BYTE_BITS) != 0
        || FRAME_BITS / BYTE_BITS > 256)
      $error("FRAME_BITS must be a multiple of 8, at most 2048");
    if (CLKS_PER_BIT < 1 || CLKS_PER_BIT > 4)
      $error("CLKS_PER_BIT must be 1 to 4");
  end

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  ctrl_s ctrl_ff;

  wire apb_done   = psel && penable && pready;
  wire apb_wr     = apb_done && pwrite;
  wire apb_rd     = apb_done && !pwrite;
  wire hit_ctrl   = (paddr == CTRL_OFS);
  wire hit_status = (paddr == STATUS_OFS);
  wire hit_rxdata = (paddr == RXDATA_OFS);
  wire hit_frames = (paddr == FRAMES_OFS);
  wire addr_ok    = hit_ctrl || hit_status || hit_rxdata || hit_frames;

  // Values above the documented reach are held at the top end
  wire [2:0] offset_eff = (ctrl_ff.stream_offset_bits > OFFSET_MAX)
                          ? OFFSET_MAX : ctrl_ff.stream_offset_bits;

  // Rising edge for native/clear and GCI/set, falling otherwise
  wire sample_on_rise = ctrl_ff.native_serial_mode
                        ^ ctrl_ff.latch_edge_select;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff.enable             <= CTRL_RESET[CTRL_ENABLE_BIT];
      ctrl_ff.native_serial_mode <= CTRL_RESET[CTRL_NATIVE_BIT];
      ctrl_ff.latch_edge_select  <= CTRL_RESET[CTRL_LATCH_BIT];
      ctrl_ff.stream_offset_bits <= CTRL_RESET[CTRL_OFS_MSB:CTRL_OFS_LSB];
    end
    else if (apb_wr && hit_ctrl)
    begin
      ctrl_ff.enable             <= pwdata[CTRL_ENABLE_BIT];
      ctrl_ff.native_serial_mode <= pwdata[CTRL_NATIVE_BIT];
      ctrl_ff.latch_edge_select  <= pwdata[CTRL_LATCH_BIT];
      ctrl_ff.stream_offset_bits <= pwdata[CTRL_OFS_MSB:CTRL_OFS_LSB];
    end
  end

  // ------------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------------
  logic edge_pulse;
  logic data_bit;
  logic frame_bit;

  serial_edge_sampler u_sampler (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .serial_clock        (serial_clock),
    .serial_stream_input (serial_stream_input),
    .frame_pulse_input   (frame_pulse_input),
    .sample_on_rise      (sample_on_rise),
    .edge_pulse          (edge_pulse),
    .data_bit            (data_bit),
    .frame_bit           (frame_bit)
  );

  // ------------------------------------------------------------------
  // Frame alignment
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_HUNT, ST_DELAY, ST_RUN} align_e;

  align_e          state_ff;
  align_e          nxt_state;
  logic            frame_prev_ff;
  logic [2:0]      delay_ff;
  logic [2:0]      nxt_delay;
  logic [PW-1:0]   phase_ff;
  logic [PW-1:0]   nxt_phase;
  logic [BW-1:0]   bit_cnt_ff;
  logic [BW-1:0]   nxt_bit_cnt;
  logic [7:0]      shift_ff;
  logic            take_bit;
  logic            resync_evt;

  wire frame_ref = edge_pulse && frame_bit && !frame_prev_ff;
  wire last_bit  = (bit_cnt_ff == BW'(FRAME_BITS - 1));
  wire [7:0] shift_in = {shift_ff[6:0], data_bit};
  wire byte_done = take_bit && (bit_cnt_ff[2:0] == 3'h7);
  wire [7:0] chan_now = 8'(bit_cnt_ff >> 3);

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_delay   = delay_ff;
    nxt_phase   = phase_ff;
    nxt_bit_cnt = bit_cnt_ff;
    take_bit    = 1'b0;
    resync_evt  = 1'b0;
    unique case (state_ff)
      ST_IDLE:
        if (ctrl_ff.enable)
          nxt_state = ST_HUNT;
      ST_HUNT, ST_DELAY, ST_RUN:
        if (!ctrl_ff.enable)
          nxt_state = ST_IDLE;
        else if (frame_ref)
        begin
          // Offset counts whole periods from the frame reference edge
          nxt_state   = ST_DELAY;
          nxt_delay   = offset_eff;
          nxt_bit_cnt = '0;
          resync_evt  = (state_ff == ST_RUN) || (state_ff == ST_DELAY);
        end
        else if (edge_pulse && state_ff == ST_DELAY)
        begin
          if (delay_ff == 3'h0)
          begin
            // Bit 0 of the new frame is taken on this edge
            take_bit    = 1'b1;
            nxt_state   = ST_RUN;
            nxt_phase   = PW'(CLKS_PER_BIT - 1);
            nxt_bit_cnt = BW'(1);
          end
          else
            nxt_delay = delay_ff - 3'h1;
        end
        else if (edge_pulse && state_ff == ST_RUN)
        begin
          if (phase_ff != '0)
            nxt_phase = phase_ff - 1'b1;
          else
          begin
            take_bit    = 1'b1;
            nxt_phase   = PW'(CLKS_PER_BIT - 1);
            nxt_bit_cnt = bit_cnt_ff + 1'b1;
            if (last_bit)
              nxt_state = ST_HUNT;
          end
        end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff      <= ST_IDLE;
      frame_prev_ff <= 1'b0;
      delay_ff      <= 3'h0;
      phase_ff      <= '0;
      bit_cnt_ff    <= '0;
      shift_ff      <= 8'h00;
    end
    else
    begin
      state_ff   <= nxt_state;
      delay_ff   <= nxt_delay;
      phase_ff   <= nxt_phase;
      bit_cnt_ff <= nxt_bit_cnt;
      if (edge_pulse)
        frame_prev_ff <= frame_bit;
      if (take_bit)
        shift_ff <= shift_in;
    end
  end

  // ------------------------------------------------------------------
  // Byte hand-off into the FIFO
  // ------------------------------------------------------------------
  // One word may wait for the FIFO; a second one arriving meanwhile
  // cannot stall the line, so it is dropped and flagged.
  rx_word_s pend_ff;
  logic     pend_valid_ff;
  logic     fifo_in_ready;
  logic     fifo_out_valid;
  logic     fifo_pop;
  rx_word_s fifo_head;
  logic     overrun_evt;

  wire pend_taken = pend_valid_ff && fifo_in_ready;
  wire pend_free  = !pend_valid_ff || pend_taken;
  assign overrun_evt = byte_done && !pend_free;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_valid_ff <= 1'b0;
      pend_ff       <= '0;
    end
    else if (byte_done && pend_free)
    begin
      pend_valid_ff <= 1'b1;
      pend_ff.sof   <= (chan_now == 8'h00);
      pend_ff.chan  <= chan_now;
      pend_ff.data  <= shift_in;
    end
    else if (pend_taken)
      pend_valid_ff <= 1'b0;
  end

  rx_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (pend_valid_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_ff),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_head)
  );

  assign fifo_pop = apb_rd && hit_rxdata && prdata[RXD_VALID_BIT];

  // ------------------------------------------------------------------
  // Status and frame count
  // ------------------------------------------------------------------
  logic       overrun_ff;
  logic       resync_ff;
  logic [7:0] frames_ff;

  wire clr_overrun = apb_wr && hit_status && pwdata[STAT_OVERRUN_BIT];
  wire clr_resync  = apb_wr && hit_status && pwdata[STAT_RESYNC_BIT];
  wire locked_now  = (state_ff == ST_RUN);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_ff   <= 1'b0;
      resync_ff    <= 1'b0;
      frames_ff    <= 8'h00;
      frame_locked <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle
      overrun_ff   <= overrun_evt || (overrun_ff && !clr_overrun);
      resync_ff    <= resync_evt || (resync_ff && !clr_resync);
      frame_locked <= locked_now;
      if (take_bit && state_ff == ST_DELAY)
        frames_ff <= frames_ff + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // APB read path and answer
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_mux[CTRL_ENABLE_BIT]           = ctrl_ff.enable;
      rd_mux[CTRL_NATIVE_BIT]           = ctrl_ff.native_serial_mode;
      rd_mux[CTRL_LATCH_BIT]            = ctrl_ff.latch_edge_select;
      rd_mux[CTRL_OFS_MSB:CTRL_OFS_LSB] = ctrl_ff.stream_offset_bits;
    end
    else if (hit_status)
    begin
      rd_mux[STAT_NOT_EMPTY_BIT] = fifo_out_valid;
      rd_mux[STAT_OVERRUN_BIT]   = overrun_ff;
      rd_mux[STAT_RESYNC_BIT]    = resync_ff;
      rd_mux[STAT_LOCKED_BIT]    = locked_now;
    end
    else if (hit_rxdata && fifo_out_valid)
    begin
      rd_mux[RXD_VALID_BIT]            = 1'b1;
      rd_mux[RXD_SOF_BIT]              = fifo_head.sof;
      rd_mux[RXD_CHAN_LSB+7:RXD_CHAN_LSB] = fifo_head.chan;
      rd_mux[7:0]                      = fifo_head.data;
    end
    else if (hit_frames)
      rd_mux[7:0] = frames_ff;
  end

  // One wait state: the answer is registered in the first access cycle
  wire access_first = psel && penable && !pready;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access_first;
      pslverr <= access_first && !addr_ok;
      if (access_first && !pwrite)
        prdata <= rd_mux;
    end
  end

endmodule

// ==== input_frame_offset_latch_asserts.sv ====
/*
  Concurrent checks on the ports of the serial input frame aligner.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module input_frame_offset_latch_asserts
  import frame_align_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_clock,
  input wire logic        serial_stream_input,
  input wire logic        frame_pulse_input,
  input wire logic        frame_locked
);
  // ----------------------------------------
  // Shadow of the enable bit, frame pulse age
  // ----------------------------------------
  logic       en_ff;
  logic [7:0] fp_age_ff;
  wire ctrl_wr = psel && penable && pready && pwrite && (paddr == CTRL_OFS);
  wire mapped  = paddr inside {CTRL_OFS, STATUS_OFS, RXDATA_OFS, FRAMES_OFS};

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      en_ff     <= CTRL_RESET[CTRL_ENABLE_BIT];
      fp_age_ff <= 8'hFF;
    end
    else
    begin
      if (ctrl_wr)
        en_ff <= pwdata[CTRL_ENABLE_BIT];
      if (frame_pulse_input)
        fp_age_ff <= 8'h00;
      else if (fp_age_ff != 8'hFF)
        fp_age_ff <= fp_age_ff + 8'h01;
    end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held");
  property p_ready_lat; (psel && penable && !pready) |=> pready; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("pready late");
  property p_ready_cause; pready |-> psel && penable && $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_err_addr; pready |-> (pslverr == !mapped); endproperty
  a_err_addr: assert property (p_err_addr) else $error("pslverr wrong");
  property p_err_data; (pready && pslverr && !pwrite) |-> (prdata == 32'h0); endproperty
  a_err_data: assert property (p_err_data) else $error("data on error");
  property p_lock_en; $rose(frame_locked) |-> en_ff; endproperty
  a_lock_en: assert property (p_lock_en) else $error("lock while off");
  property p_lock_off; $fell(en_ff) |-> ##[0:4] !frame_locked; endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock stays");
  property p_lock_pulse; $rose(frame_locked) |-> fp_age_ff <= 8'h3C; endproperty
  a_lock_pulse: assert property (p_lock_pulse) else $error("lock too late");
endmodule

// ==== serial_framer_model.sv ====
/*
  Upstream serial framer: makes the bit clock, frame pulse and stream.
  Assumes clk_sys; the bit clock stands still between frames.
*/
`timescale 1ns/1ps
module serial_framer_model #(
  parameter int FB   = 16,
  parameter int CPB  = 2,
  parameter int HALF = 4
) (
  input  wire logic clk_sys,
  output logic      serial_clock,
  output logic      serial_stream_input,
  output logic      frame_pulse_input
);
  initial
  begin
    serial_clock        = 1'b0;
    serial_stream_input = 1'b0;
    frame_pulse_input   = 1'b0;
  end

  // Non-sampled edges carry the inverse bit so a wrong edge shows
  task automatic send_frame(input logic rise, input int off, input logic [FB-1:0] fr);
    int   j;
    int   idx;
    logic d;
    @(posedge clk_sys);
    serial_clock <= rise;
    for (int k = -2; k <= off + CPB * FB; k++)
    begin
      repeat (HALF / 2) @(posedge clk_sys);
      serial_stream_input <= ~serial_stream_input;
      repeat (HALF - HALF / 2) @(posedge clk_sys);
      serial_clock <= ~rise;
      repeat (HALF / 2) @(posedge clk_sys);
      j = k - off - 1;
      idx = (j < 0) ? 0 : j / CPB + int'((j % CPB) != 0);
      if (idx > FB - 1)
        idx = FB - 1;
      d = fr[FB - 1 - idx];
      frame_pulse_input <= (k == 0);
      serial_stream_input <= (j >= 0 && j % CPB == 0) ? d : ~d;
      repeat (HALF - HALF / 2) @(posedge clk_sys);
      serial_clock <= rise;
    end
    repeat (HALF) @(posedge clk_sys);
    serial_stream_input <= ~serial_stream_input;
  endtask
endmodule

// ==== input_frame_offset_latch_bench.sv ====
/*
  Self-checking bench for the serial input frame aligner.
  Assumes the framer model and the checker file are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module input_frame_offset_latch_bench;
  import frame_align_pkg::*;
  localparam int FB = 16;
  logic          clk_sys;
  logic          reset_n;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          frame_locked;
  wire logic     sclk;
  wire logic     sdat;
  wire logic     fpul;
  logic [31:0]   v;
  logic          err;
  logic [FB-1:0] frs [5];
  int            err_total;
  int            n_compared;
  int            nfr;

  always #2.5 clk_sys = ~clk_sys;

  input_frame_offset_latch #(.FRAME_BITS(FB)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock(sclk),
    .serial_stream_input(sdat), .frame_pulse_input(fpul), .frame_locked(frame_locked));

  serial_framer_model #(.FB(FB)) far_u (.clk_sys(clk_sys), .serial_clock(sclk),
    .serial_stream_input(sdat), .frame_pulse_input(fpul));

  // ----------------------------------------
  // Bus cycles and expectations
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      err_total++;
      $display("[ERR] t=%0t no bus answer", $time);
      end_of_test;
    end
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] rx_word(int ch, logic [FB-1:0] fr);
    logic [31:0] w;
    w = 32'h0;
    w[RXD_VALID_BIT] = 1'b1;
    w[RXD_SOF_BIT] = (ch == 0);
    w[RXD_CHAN_LSB +: 8] = ch[7:0];
    w[7:0] = fr[FB - 1 - 8 * ch -: 8];
    return w;
  endfunction

  function automatic logic [31:0] ctrl_w(logic nat, logic lat, int off);
    logic [31:0] w;
    w = 32'h0;
    w[CTRL_ENABLE_BIT] = 1'b1;
    w[CTRL_NATIVE_BIT] = nat;
    w[CTRL_LATCH_BIT] = lat;
    w[CTRL_OFS_MSB:CTRL_OFS_LSB] = off[2:0];
    return w;
  endfunction

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    $display("[ERR] t=%0t watchdog expired", $time);
    end_of_test;
  end

  initial
  begin
    int            m;
    int            off;
    logic [FB-1:0] fr;
    clk_sys = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; err_total = 0; n_compared = 0; nfr = 0;
    void'($urandom(32'hB305_4FCE));
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset value, unmapped place, disabled receiver
    apb(1'b0, CTRL_OFS, 32'h0); `CHK(v, CTRL_RESET);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF); `CHK(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0); `CHK({err, v}, {1'b1, 32'h0});
    apb(1'b0, CTRL_OFS, 32'h0); `CHK(v, CTRL_RESET);
    far_u.send_frame(1'b1, 0, 16'hA5C3);
    apb(1'b0, FRAMES_OFS, 32'h0); `CHK(v, 32'h0);
    apb(1'b0, RXDATA_OFS, 32'h0); `CHK(v, 32'h0);
    // Every mode and latch edge, offsets 0, 4, 7 and random
    for (int i = 0; i < 6; i++)
    begin
      m = i % 4;
      off = (i == 0) ? 0 : (i == 1) ? 4 : (i == 2) ? 7 : int'($urandom % 8);
      fr = FB'($urandom);
      apb(1'b1, CTRL_OFS, ctrl_w(m[1], m[0], off));
      far_u.send_frame(m[1] ^ m[0], (off > 4) ? 4 : off, fr);
      nfr++;
      repeat (20) @(posedge clk_sys);
      for (int c = 0; c < 2; c++)
      begin
        apb(1'b0, RXDATA_OFS, 32'h0);
        `CHK(v, rx_word(c, fr));
      end
      apb(1'b0, FRAMES_OFS, 32'h0); `CHK(v[7:0], nfr[7:0]);
      apb(1'b0, STATUS_OFS, 32'h0); `CHK(v, 32'h0);
    end
    // Fill past the FIFO, then drain it and clear the overrun
    apb(1'b1, CTRL_OFS, ctrl_w(1'b1, 1'b0, 2));
    for (int f = 0; f < 5; f++)
    begin
      frs[f] = FB'($urandom);
      far_u.send_frame(1'b1, 2, frs[f]);
      nfr++;
    end
    repeat (20) @(posedge clk_sys);
    apb(1'b0, STATUS_OFS, 32'h0); `CHK(v[1:0], 2'b11);
    for (int k = 0; k < 9; k++)
    begin
      apb(1'b0, RXDATA_OFS, 32'h0); `CHK(v, rx_word(k % 2, frs[k / 2]));
    end
    apb(1'b0, RXDATA_OFS, 32'h0); `CHK(v, 32'h0);
    apb(1'b1, STATUS_OFS, 32'h2);
    apb(1'b0, STATUS_OFS, 32'h0); `CHK(v, 32'h0);
    // Frame shorter than the offset allows: first byte lands late, the
    // next pulse arrives mid-frame and restarts the aligner
    apb(1'b1, CTRL_OFS, ctrl_w(1'b0, 1'b1, 4));
    fr = FB'($urandom);
    far_u.send_frame(1'b1, 0, fr);
    `CHK(frame_locked, 1'b1);
    far_u.send_frame(1'b1, 4, frs[0]);
    nfr += 2;
    repeat (20) @(posedge clk_sys);
    `CHK(frame_locked, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0); `CHK(v[3:0], 4'h5);
    apb(1'b0, RXDATA_OFS, 32'h0); `CHK(v, rx_word(0, FB'(fr << 2)));
    for (int c = 0; c < 2; c++)
    begin
      apb(1'b0, RXDATA_OFS, 32'h0); `CHK(v, rx_word(c, frs[0]));
    end
    apb(1'b1, STATUS_OFS, 32'h4);
    apb(1'b0, STATUS_OFS, 32'h0); `CHK(v, 32'h0);
    apb(1'b0, FRAMES_OFS, 32'h0); `CHK(v[7:0], nfr[7:0]);
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (10) @(posedge clk_sys);
    end_of_test;
  end
endmodule

bind input_frame_offset_latch input_frame_offset_latch_asserts chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_clock(serial_clock),
  .serial_stream_input(serial_stream_input), .frame_pulse_input(frame_pulse_input),
  .frame_locked(frame_locked));
